// file: design/cfs_pkg.sv
// Constants, register map and carrier types of the flush sequencer.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses.
package cfs_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int           ADDR_W          = 8;
   localparam logic [7:0]   ADDR_CTRL       = 8'h00;
   localparam logic [7:0]   ADDR_FLUSH      = 8'h04;
   localparam logic [7:0]   ADDR_FRAME      = 8'h08;
   localparam logic [7:0]   ADDR_EXPOSE     = 8'h0c;
   localparam logic [7:0]   ADDR_IMAGES     = 8'h10;
   localparam logic [7:0]   ADDR_STATUS     = 8'h14;
   localparam int           CTRL_LOAD_BIT   = 0;
   localparam int           CTRL_EXT_BIT    = 1;
   localparam int           CTRL_CONT_BIT   = 2;
   localparam int           CTRL_FORCE_BIT  = 3;
   localparam int           CTRL_START_BIT  = 4;
   localparam int           FLUSH_EXTRA_LSB = 0;
   localparam int           FLUSH_RPF_LSB   = 8;
   localparam int           FRAME_ACT_LSB   = 0;
   localparam int           FRAME_BLANK_LSB = 16;
   localparam int           STAT_PEND_BIT   = 8;
   localparam int           STAT_IMG_LSB    = 16;
   localparam logic [7:0]   EXTRA_RST       = 8'h01;
   localparam logic [15:0]  RPF_RST         = 16'h0002;
   localparam logic [15:0]  ACTIVE_RST      = 16'h0010;
   localparam logic [7:0]   BLANK_RST       = 8'h00;
   localparam logic [23:0]  EXPOSE_RST      = 24'h0003e8;
   localparam logic [7:0]   IMAGES_RST      = 8'h01;
   localparam logic [1:0]   RESP_OKAY       = 2'b00;
   localparam logic [1:0]   RESP_SLVERR     = 2'b10;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_FLUSH = 8'h02,
      ST_EXTRA = 8'h04,
      ST_WAIT  = 8'h08,
      ST_EXPOS = 8'h10,
      ST_BLANK = 8'h20,
      ST_SLFL  = 8'h40,
      ST_READ  = 8'h80
   } cfs_state_t;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } cfs_axil_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } cfs_axil_rsp_t;

   typedef struct packed {
      logic unload;
      logic row_discard;
      logic blank_shift;
      logic line_flush;
      logic row_read;
   } cfs_sens_t;
endpackage

// file: design/cfs_flush_seq.sv
// Flush sequencer: dark-charge flushing, exposure start and readout
// ordering for an intensified imaging sensor, with AXI4-Lite registers.
// Assumes all inputs synchronous to aclk and one AXI4-Lite master.
// Function
// - Idle: repeat flush cycles, each discarding rows from the array
// - Flushing starts once a flush pattern is loaded, without a request
// - After begin-capture, finish one last flush cycle, then expose
// - Multi-image: flush before first exposure and after last readout
// - No flush cycles between consecutive exposures of one acquisition; code discards rows there in ST_WAIT when cont is set
// - Extra-flush count adds cycles after request and current cycle
// - Rows-per-flush sets rows discarded in each flush cycle
// - Request arriving mid-cycle waits until that cycle completes
// - Flush-until-trigger only when exposure start waits for trigger
// - Leading blank rows shifted through the line flush it
// - No blank rows and force option: flush line before readout
// - Nonzero extra count delays start by exactly that many cycles
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cfs_flush_seq
   import cfs_pkg::*;
#(
   parameter logic [7:0]  EXTRA_RESET = EXTRA_RST,
   parameter logic [15:0] RPF_RESET   = RPF_RST
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          ce,
   input  wire cfs_axil_req_t axi_req,
   output var  cfs_axil_rsp_t axi_rsp,
   input  wire logic          trig_i,
   output var  cfs_sens_t     sens_o
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      cfs_state_t        st;
      logic              pend;
      logic [15:0]       row_cnt;
      logic [7:0]        extra_left;
      logic [23:0]       exp_cnt;
      logic [7:0]        img_left;
      logic              loaded;
      logic              ext_sync;
      logic              cont;
      logic              force_fl;
      logic [7:0]        extra;
      logic [15:0]       rpf;
      logic [15:0]       active;
      logic [7:0]        blank;
      logic [23:0]       expose;
      logic [7:0]        images;
      logic              aw_got;
      logic              w_got;
      logic [ADDR_W-1:0] awaddr;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      cfs_sens_t         sens;
   } cfs_regs_t;

   localparam cfs_regs_t S_RST = '{st: ST_IDLE, extra: EXTRA_RESET,
      rpf: RPF_RESET, active: ACTIVE_RST, blank: BLANK_RST,
      expose: EXPOSE_RST, images: IMAGES_RST, img_left: IMAGES_RST,
      sens: '{unload: 1'b1, default: 1'b0}, default: '0};

   if (RPF_RESET == 16'h0000) begin
      $error("rows per flush reset must be nonzero");
   end

   cfs_regs_t s_r;
   cfs_regs_t s_nxt;
   logic      flush_end;
   logic      blank_end;
   logic      read_end;
   logic      exp_end;
   logic      start_exp;
   logic      start_req;
   logic [31:0] wmerged;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic last_row(input logic [15:0] cnt,
                                     input logic [15:0] len);
      last_row = ({1'b0, cnt} + 17'h00001) >= {1'b0, len};
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == ADDR_CTRL) || (a == ADDR_FLUSH) ||
               (a == ADDR_FRAME) || (a == ADDR_EXPOSE) ||
               (a == ADDR_IMAGES) || (a == ADDR_STATUS);
   endfunction

   function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a,
                                           input cfs_regs_t s);
      rd_word = 32'h00000000;
      case (a)
         ADDR_CTRL: begin
            rd_word[CTRL_LOAD_BIT]  = s.loaded;
            rd_word[CTRL_EXT_BIT]   = s.ext_sync;
            rd_word[CTRL_CONT_BIT]  = s.cont;
            rd_word[CTRL_FORCE_BIT] = s.force_fl;
         end
         ADDR_FLUSH: begin
            rd_word[FLUSH_EXTRA_LSB +: 8] = s.extra;
            rd_word[FLUSH_RPF_LSB +: 16]  = s.rpf;
         end
         ADDR_FRAME: begin
            rd_word[FRAME_ACT_LSB +: 16]  = s.active;
            rd_word[FRAME_BLANK_LSB +: 8] = s.blank;
         end
         ADDR_EXPOSE: rd_word[23:0] = s.expose;
         ADDR_IMAGES: rd_word[7:0] = s.images;
         ADDR_STATUS: begin
            rd_word[7:0]              = s.st;
            rd_word[STAT_PEND_BIT]    = s.pend;
            rd_word[STAT_IMG_LSB +: 8] = s.img_left;
         end
         default: rd_word = 32'h00000000;
      endcase
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  strb);
      for (int i = 0; i < 4; i++) begin
         wmerge[i*8 +: 8] = strb[i] ? d[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   assign flush_end = last_row(s_r.row_cnt, s_r.rpf);
   assign blank_end = last_row(s_r.row_cnt, {8'h00, s_r.blank});
   assign read_end  = last_row(s_r.row_cnt, s_r.active);
   assign exp_end   = s_r.exp_cnt <= 24'h000001;
   assign wmerged   = wmerge(rd_word(s_r.awaddr, s_r), s_r.wdata,
                             s_r.wstrb);

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.sens = '{unload: 1'b1, default: 1'b0};
      start_exp = 1'b0;
      start_req = 1'b0;
      case (s_r.st)
         ST_IDLE: begin
            if (s_r.loaded) begin
               s_nxt.st = ST_FLUSH;
               s_nxt.row_cnt = 16'h0000;
            end
         end
         ST_FLUSH: begin
            s_nxt.sens.row_discard = 1'b1;
            s_nxt.row_cnt = s_r.row_cnt + 16'h0001;
            if (flush_end) begin
               s_nxt.row_cnt = 16'h0000;
               if (!s_r.loaded) begin
                  s_nxt.st = ST_IDLE;
               end else if (s_r.pend && s_r.extra != 8'h00) begin
                  s_nxt.st = ST_EXTRA;
                  s_nxt.extra_left = s_r.extra;
               end else if (s_r.pend) begin
                  start_exp = 1'b1;
               end
            end
         end
         ST_EXTRA: begin
            s_nxt.sens.row_discard = 1'b1;
            s_nxt.row_cnt = s_r.row_cnt + 16'h0001;
            if (flush_end) begin
               s_nxt.row_cnt = 16'h0000;
               s_nxt.extra_left = s_r.extra_left - 8'h01;
               if (s_r.extra_left <= 8'h01) begin
                  start_exp = 1'b1;
               end
            end
         end
         ST_WAIT: begin
            s_nxt.sens.row_discard = s_r.cont;
            if (trig_i) begin
               s_nxt.st = ST_EXPOS;
               s_nxt.exp_cnt = s_r.expose;
            end
         end
         ST_EXPOS: begin
            s_nxt.exp_cnt = s_r.exp_cnt - 24'h000001;
            s_nxt.row_cnt = 16'h0000;
            if (exp_end) begin
               if (s_r.blank != 8'h00) begin
                  s_nxt.st = ST_BLANK;
               end else if (s_r.force_fl) begin
                  s_nxt.st = ST_SLFL;
               end else begin
                  s_nxt.st = ST_READ;
               end
            end
         end
         ST_BLANK: begin
            s_nxt.sens.blank_shift = 1'b1;
            s_nxt.row_cnt = s_r.row_cnt + 16'h0001;
            if (blank_end) begin
               s_nxt.st = ST_READ;
               s_nxt.row_cnt = 16'h0000;
            end
         end
         ST_SLFL: begin
            s_nxt.sens.line_flush = 1'b1;
            s_nxt.st = ST_READ;
         end
         ST_READ: begin
            s_nxt.sens.row_read = 1'b1;
            s_nxt.row_cnt = s_r.row_cnt + 16'h0001;
            if (read_end) begin
               s_nxt.row_cnt = 16'h0000;
               if (s_r.img_left > 8'h01) begin
                  s_nxt.img_left = s_r.img_left - 8'h01;
                  s_nxt.st = s_r.ext_sync ? ST_WAIT : ST_EXPOS;
                  s_nxt.exp_cnt = s_r.expose;
               end else begin
                  s_nxt.st = ST_FLUSH;
               end
            end
         end
         default: s_nxt.st = ST_IDLE;
      endcase
      if (start_exp) begin
         s_nxt.img_left = (s_r.images == 8'h00) ? 8'h01 : s_r.images;
         s_nxt.st = s_r.ext_sync ? ST_WAIT : ST_EXPOS;
         s_nxt.exp_cnt = s_r.expose;
      end
      // Lags the state like the row strobes: no discard overlaps exposure
      s_nxt.sens.unload = (s_r.st != ST_EXPOS);

      // Register bus: address and data taken in either order
      if (axi_req.awvalid && !s_r.aw_got && !s_r.bvalid) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = axi_req.awaddr;
      end
      if (axi_req.wvalid && !s_r.w_got && !s_r.bvalid) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = axi_req.wdata;
         s_nxt.wstrb = axi_req.wstrb;
      end
      if (s_r.aw_got && s_r.w_got) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = mapped(s_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_r.awaddr)
            ADDR_CTRL: begin
               s_nxt.loaded   = wmerged[CTRL_LOAD_BIT];
               s_nxt.ext_sync = wmerged[CTRL_EXT_BIT];
               s_nxt.cont     = wmerged[CTRL_CONT_BIT];
               s_nxt.force_fl = wmerged[CTRL_FORCE_BIT];
               start_req = s_r.wstrb[0] && s_r.wdata[CTRL_START_BIT];
            end
            ADDR_FLUSH: begin
               s_nxt.extra = wmerged[FLUSH_EXTRA_LSB +: 8];
               s_nxt.rpf   = wmerged[FLUSH_RPF_LSB +: 16];
            end
            ADDR_FRAME: begin
               s_nxt.active = wmerged[FRAME_ACT_LSB +: 16];
               s_nxt.blank  = wmerged[FRAME_BLANK_LSB +: 8];
            end
            ADDR_EXPOSE: s_nxt.expose = wmerged[23:0];
            ADDR_IMAGES: s_nxt.images = wmerged[7:0];
            default: s_nxt.bresp = s_nxt.bresp;
         endcase
      end
      if (s_r.bvalid && axi_req.bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (axi_req.arvalid && !s_r.rvalid) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = rd_word(axi_req.araddr, s_r);
         s_nxt.rresp = mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_r.rvalid && axi_req.rready) begin
         s_nxt.rvalid = 1'b0;
      end
      // A new request wins over the consume of the previous one
      s_nxt.pend = (s_r.pend && !start_exp) || start_req;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= S_RST;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign sens_o          = s_r.sens;
   assign axi_rsp.awready = !s_r.aw_got && !s_r.bvalid;
   assign axi_rsp.wready  = !s_r.w_got && !s_r.bvalid;
   assign axi_rsp.bvalid  = s_r.bvalid;
   assign axi_rsp.bresp   = s_r.bresp;
   assign axi_rsp.arready = !s_r.rvalid;
   assign axi_rsp.rvalid  = s_r.rvalid;
   assign axi_rsp.rdata   = s_r.rdata;
   assign axi_rsp.rresp   = s_r.rresp;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_mid_flush;
      ce && s_r.st == ST_FLUSH && !flush_end;
   endsequence
   sequence s_cycle_done;
      ce && s_r.st == ST_FLUSH && flush_end && s_r.loaded && s_r.pend;
   endsequence

   property p_flush_rows;
      ce && s_r.st == ST_FLUSH |=> s_r.sens.row_discard;
   endproperty
   a_flush_rows: assert property (p_flush_rows)
      else $error("flush cycle did not discard a row");

   property p_auto_flush;
      ce && s_r.st == ST_IDLE && s_r.loaded |=> s_r.st == ST_FLUSH;
   endproperty
   a_auto_flush: assert property (p_auto_flush)
      else $error("flushing did not start after pattern load");

   property p_hold_mid;
      s_mid_flush |=> s_r.st == ST_FLUSH && s_r.sens.unload;
   endproperty
   a_hold_mid: assert property (p_hold_mid)
      else $error("exposure started inside a flush cycle");

   property p_pend_kept;
      s_mid_flush and s_r.pend |=> s_r.pend;
   endproperty
   a_pend_kept: assert property (p_pend_kept)
      else $error("pending request was lost");

   property p_extra;
      s_cycle_done and s_r.extra != 8'h00 |=>
         s_r.st == ST_EXTRA && s_r.extra_left == $past(s_r.extra);
   endproperty
   a_extra: assert property (p_extra)
      else $error("extra flush cycles not entered");

   property p_no_extra;
      s_cycle_done and s_r.extra == 8'h00 and !s_r.ext_sync |=>
         s_r.st == ST_EXPOS ##1 !s_r.sens.unload;
   endproperty
   a_no_extra: assert property (p_no_extra)
      else $error("zero extra count delayed exposure");

   property p_unload;
      $fell(s_r.sens.unload) |->
         $past(s_r.st) == ST_EXPOS && !s_r.sens.row_discard;
   endproperty
   a_unload: assert property (p_unload)
      else $error("unload fell outside an exposure start");

   property p_skip_free;
      ce && s_r.st == ST_READ && read_end && s_r.img_left > 8'h01 |=>
         s_r.st inside {ST_EXPOS, ST_WAIT};
   endproperty
   a_skip_free: assert property (p_skip_free)
      else $error("flush inserted between exposures");

   property p_after_last;
      ce && s_r.st == ST_READ && read_end && s_r.img_left <= 8'h01 |=>
         s_r.st == ST_FLUSH;
   endproperty
   a_after_last: assert property (p_after_last)
      else $error("no flush after last readout");

   property p_blank;
      ce && s_r.st == ST_EXPOS && exp_end && s_r.blank != 8'h00 |=>
         s_r.st == ST_BLANK ##1 s_r.sens.blank_shift;
   endproperty
   a_blank: assert property (p_blank)
      else $error("blank rows did not flush the line");

   property p_force;
      ce && s_r.st == ST_EXPOS && exp_end && s_r.blank == 8'h00 &&
      s_r.force_fl |=> s_r.st == ST_SLFL ##1 s_r.sens.line_flush;
   endproperty
   a_force: assert property (p_force)
      else $error("forced line flush missing");

   property p_wait_sync;
      s_r.st == ST_WAIT |-> s_r.ext_sync || $past(s_r.ext_sync);
   endproperty
   a_wait_sync: assert property (p_wait_sync)
      else $error("trigger wait without external sync");
endmodule
`default_nettype wire

// file: verification/cfs_trig_src.sv
// Trigger source model for the external sync input of the sequencer.
// Assumes the aclk domain; raises trig a given delay after arm rises.
`timescale 1ns/1ps
`default_nettype none
module cfs_trig_src (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       arm,
   input  wire logic [7:0] delay,
   output var  logic       trig
);
   logic [7:0] cnt;

   // Level trigger, held until disarmed
   always @(posedge aclk) begin
      if (!aresetn || !arm) begin
         cnt  <= 8'h00;
         trig <= 1'b0;
      end else if (cnt < delay) begin
         cnt <= cnt + 8'h01;
      end else begin
         trig <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: verification/ccd_flush_sequencer_tb.sv
// Testbench of the flush sequencer: register resets, flush and exposure
// ordering, readout framing, trigger-gated start and mid-run reset.
// Assumes cfs_pkg, cfs_flush_seq and the trigger source model.
`timescale 1ns/1ps
`default_nettype none
module ccd_flush_sequencer_tb
   import cfs_pkg::*;
;
   typedef struct {
      int rpf;
      int xtra;
      int blank;
      int frc;
      int img;
   } cfs_row_t;
   typedef struct {
      logic [7:0]  a;
      logic [31:0] d;
      logic [1:0]  r;
   } cfs_rv_t;

   logic          aclk            = 1'b0;
   logic          aresetn         = 1'b0;
   logic          ce              = 1'b1;
   logic          arm             = 1'b0;
   logic          trig;
   logic          prev_u;
   logic [1:0]    resp;
   logic [31:0]   rdat;
   cfs_axil_req_t req             = '0;
   cfs_axil_rsp_t rsp;
   cfs_sens_t     sens;
   int            error_cnt       = 0;
   int            samples_checked = 0;
   int            tot, acq_d, bl, lf, rd, lo, falls, fall_tot, exp_rd;

   cfs_rv_t  rv [6] = '{
      '{ADDR_CTRL,   32'h00000000, RESP_OKAY},
      '{ADDR_FLUSH,  32'h00000201, RESP_OKAY},
      '{ADDR_FRAME,  32'h00000010, RESP_OKAY},
      '{ADDR_EXPOSE, 32'h000003e8, RESP_OKAY},
      '{ADDR_IMAGES, 32'h00000001, RESP_OKAY},
      '{8'h18,       32'h00000000, RESP_SLVERR}
   };
   cfs_row_t rows [4] = '{
      '{2, 1, 0, 0, 1},
      '{1, 0, 2, 0, 3},
      '{3, 2, 0, 1, 2},
      '{8, 1, 1, 1, 1}
   };

   always #50 aclk = ~aclk;

   cfs_flush_seq cfs_flush_seq_inst (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .axi_req (req),
      .axi_rsp (rsp),
      .trig_i  (trig),
      .sens_o  (sens)
   );
   cfs_trig_src cfs_trig_src_inst (
      .aclk    (aclk),
      .aresetn (aresetn),
      .arm     (arm),
      .delay   (8'h03),
      .trig    (trig)
   );

   // ---------------------------------------------------------------
   // Sensor output monitor
   // ---------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         {tot, acq_d, bl, lf, rd, lo, falls, fall_tot} <= '0;
         prev_u <= 1'b1;
      end else begin
         tot <= tot + 32'(sens.row_discard);
         if (sens.row_discard && falls != 0 && rd < exp_rd) begin
            acq_d <= acq_d + 1;
         end
         bl <= bl + 32'(sens.blank_shift);
         lf <= lf + 32'(sens.line_flush);
         rd <= rd + 32'(sens.row_read);
         lo <= lo + 32'(!sens.unload);
         if (prev_u && !sens.unload) begin
            falls <= falls + 1;
            if (falls == 0) begin
               fall_tot <= tot;
            end
         end
         prev_u <= sens.unload;
      end
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic do_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      req     <= '0;
      cyc(4);
      aresetn <= 1'b1;
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
      @(posedge aclk);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hf;
      req.bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid);
      r = rsp.bresp;
      req.bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
      @(posedge aclk);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid);
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'b0;
   endtask

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked,
               error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      int       a;
      int       lo_x;
      cfs_row_t s;
      exp_rd = 0;
      do_reset();
      foreach (rv[i]) begin
         axr(rv[i].a, rdat, resp);
         chk("reset rdata", rdat, rv[i].d);
         chk("rresp", 32'(resp), 32'(rv[i].r));
      end
      axw(8'h1c, 32'h00000001, resp);
      chk("unmapped bresp", 32'(resp), 32'(RESP_SLVERR));
      $display("register test done");
      foreach (rows[i]) begin
         s = rows[i];
         do_reset();
         exp_rd = 3 * s.img;
         axw(ADDR_FLUSH, 32'(s.rpf * 256 + s.xtra), resp);
         axw(ADDR_FRAME, 32'(s.blank * 65536 + 3), resp);
         axw(ADDR_EXPOSE, 32'h00000005, resp);
         axw(ADDR_IMAGES, 32'(s.img), resp);
         chk("no flush unloaded", tot, 0);
         axw(ADDR_CTRL, 32'(s.frc * 8 + 1), resp);
         cyc(7);
         chk("idle flushing", tot > 0, 1);
         a = tot;
         axw(ADDR_CTRL, 32'(s.frc * 8 + 17), resp);
         if (s.xtra * s.rpf >= 6) begin
            axr(ADDR_STATUS, rdat, resp);
            chk("pending", rdat[STAT_PEND_BIT], 1'b1);
         end
         while (rd < exp_rd) @(posedge aclk);
         lo_x = 5 * s.img;
         chk("cycle end", 32'(fall_tot % s.rpf), 0);
         // Six rows pass from the snapshot to the request taking hold
         chk("extra rows", fall_tot - a >= s.xtra * s.rpf + 6, 1);
         chk("latency", fall_tot - a <= (s.xtra + 1) * s.rpf + 5, 1);
         chk("exposures", falls, s.img);
         chk("exposure cycles", lo, lo_x);
         chk("inter flush", acq_d, 0);
         chk("blank rows", bl, s.blank * s.img);
         chk("line flush", lf, (s.blank == 0 && s.frc == 1) * s.img);
         a = tot;
         cyc(2 * s.rpf + 8);
         chk("flush after read", tot > a, 1);
         $display("row %0d done", i);
      end
      do_reset();
      axw(ADDR_FLUSH, 32'h00000100, resp);
      axw(ADDR_EXPOSE, 32'h00000005, resp);
      axw(ADDR_CTRL, 32'h00000007, resp);
      axw(ADDR_CTRL, 32'h00000017, resp);
      a = tot;
      cyc(30);
      chk("held for trigger", falls, 0);
      chk("flush until trigger", tot > a + 20, 1);
      arm <= 1'b1;
      cyc(8);
      chk("trigger start", falls, 1);
      arm <= 1'b0;
      cyc(3);
      do_reset();
      @(posedge aclk);
      chk("unload after reset", sens.unload, 1'b1);
      axr(ADDR_CTRL, rdat, resp);
      chk("ctrl after reset", rdat, 32'h00000000);
      cyc(10);
      chk("no flush after reset", tot, 0);
      $display("trigger and reset test done");
      // Clock enable low for six edges stretches the exposure by six
      axw(ADDR_EXPOSE, 32'h00000005, resp);
      axw(ADDR_CTRL, 32'h00000011, resp);
      while (falls == 0) @(posedge aclk);
      ce <= 1'b0;
      cyc(6);
      ce <= 1'b1;
      cyc(12);
      chk("frozen exposure", lo, 11);
      chk("frozen falls", falls, 1);
      $display("clock enable test done");
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      give_verdict();
   end
endmodule
`default_nettype wire
